// ==== hw/frm_pkg.sv ====
// Purpose: shared constants and carrier types for the transform result magnitude stage
// Assumes: one clock core_clk, synchronous active-high reset srst
// Notes:   memory sizes and widths are fixed; no register bus ports are used beyond a small control and status block
//
// Functional notes
// - separate phase and quadrature result memories, 1024x16
// - transform-side result port is write only
// - user-side result port is read only
// - result memories read zero before first write
// - input/working memories start cleared to zero
// - working memory reads return one cycle later
// - two input/working banks, phase and quadrature
// - host output queue is 32 wide, 1023 deep
// - phase in low half, quadrature high half
// - queue has no almost flags or counts
// - square both phase and quadrature components
// - squarers accept new pair every cycle
// - operands are registered 16-bit signed values
// - each multiplier gives registered 16-bit result
// - multipliers use no handshake signals
// - multipliers fully pipelined, longer latency accepted
// - multiplier registers have no clear or enable
// - adder sums squares into channel A magnitude
// - adder inputs are 16-bit signed
// - adder output registered, 16 bits, one cycle
// - banks swap roles when transform completes
package frm_pkg;
	localparam int unsigned DEPTH       = 1024;
	localparam int unsigned AW          = 10;
	localparam int unsigned DW          = 16;
	localparam int unsigned QW          = 32;
	localparam int unsigned QDEPTH      = 1023;
	localparam int unsigned QPW         = 10;
	localparam logic [DW-1:0] INIT_WORD = 16'h0000;
	localparam int unsigned PROD_HI     = 30;
	localparam int unsigned PROD_LO     = 15;
	localparam int unsigned MUL_LAT     = 3;
	localparam logic [3:0]  BUS_AW      = 4'h4;
	localparam logic [3:0]  REG_CTRL    = 4'h0;
	localparam logic [3:0]  REG_STAT    = 4'h4;
	localparam logic [3:0]  REG_MAG     = 4'h8;
	localparam int unsigned CTRL_RUN    = 0;
	localparam int unsigned STAT_BANK   = 0;
	localparam int unsigned STAT_FULL   = 1;
	localparam int unsigned STAT_EMPTY  = 2;

	typedef struct packed {
		logic          we;
		logic [AW-1:0] addr;
		logic [DW-1:0] phase;
		logic [DW-1:0] quad;
	} frm_wr_t;

	typedef struct packed {
		logic          valid;
		logic [QW-1:0] data;
	} frm_word_t;

	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_SCAN = 2'b01,
		RD_LAST = 2'b11
	} frm_rd_st_t;

	function automatic logic [DW-1:0] frm_square(input logic signed [DW-1:0] v);
		logic signed [2*DW-1:0] p;
		p = v * v;
		return p[PROD_HI:PROD_LO];
	endfunction
endpackage

// ==== hw/frm_stage.sv ====
// Purpose: result side of a double-buffered 1024-point transform: result store, magnitude path, host queue
// Assumes: transform core drives the write and done strobes in its own sequence; host drains the queue
// Notes:   the two input/working banks live here too so the core sees one-cycle read data
`timescale 1ns/1ps
module frm_stage
	import frm_pkg::*;
(
	// clock and reset
	input  wire logic                      core_clk,
	input  wire logic                      srst,
	// transform core: input capture, working bank, results
	input  wire frm_pkg::frm_wr_t          cap_wr,
	input  wire frm_pkg::frm_wr_t          work_wr,
	input  wire logic [frm_pkg::AW-1:0]    work_raddr,
	output logic      [2*frm_pkg::DW-1:0]  work_rdata,
	input  wire frm_pkg::frm_wr_t          res_wr,
	input  wire logic                      xform_done,
	// converter channel A
	output logic      [frm_pkg::DW-1:0]    mag_a,
	// host output queue
	output frm_pkg::frm_word_t             host_word,
	input  wire logic                      host_ready,
	// avalon-mm slave
	input  wire logic [frm_pkg::BUS_AW-1:0] avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [31:0]               avs_writedata,
	output logic      [31:0]               avs_readdata,
	output logic                           avs_waitrequest
);
	import frm_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// memories, all but the queue cleared at start; no reset port on block memory
	logic [DW-1:0] bank_ph [2][DEPTH];
	logic [DW-1:0] bank_qd [2][DEPTH];
	logic [DW-1:0] res_ph  [DEPTH];
	logic [DW-1:0] res_qd  [DEPTH];
	logic [QW-1:0] queue   [QDEPTH];

	initial
	begin
		for (int i = 0; i < DEPTH; i++)
		begin
			bank_ph[0][i] = INIT_WORD;
			bank_ph[1][i] = INIT_WORD;
			bank_qd[0][i] = INIT_WORD;
			bank_qd[1][i] = INIT_WORD;
			res_ph[i]     = INIT_WORD;
			res_qd[i]     = INIT_WORD;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic                 bank;
		logic                 run;
		frm_rd_st_t           rd_st;
		logic [AW-1:0]        rd_addr;
		logic                 rd_v;
		logic [MUL_LAT-1:0]   mv;
		logic                 sum_v;
		logic [QPW-1:0]       wp;
		logic [QPW-1:0]       rp;
		logic [QPW:0]         cnt;
		frm_word_t            out;
		logic [QW-1:0]        pair;
		logic                 pair_v;
		logic [DW-1:0]        mag;
		logic [31:0]          rdata;
		logic                 ack;
		logic [2*DW-1:0]      wdata;
	} frm_state_t;

	frm_state_t s_q, s_d;

	// datapath registers: no clear, no enable
	logic signed [DW-1:0] op_ph_q, op_qd_q;
	logic        [DW-1:0] sq_ph_p_q, sq_qd_p_q, sq_ph_q, sq_qd_q;
	logic signed [DW-1:0] add_a_q, add_b_q;
	logic        [DW-1:0] rd_ph_q, rd_qd_q;
	logic        [QW-1:0] q_rd_q;
	logic        [2*DW-1:0] work_rd_q;

	function automatic logic [QPW-1:0] frm_inc(input logic [QPW-1:0] p);
		return (p == QPW'(QDEPTH - 1)) ? '0 : QPW'(p + 1'b1);
	endfunction

	logic q_full, q_empty, q_push, q_pop;
	assign q_full  = (s_q.cnt == (QPW+1)'(QDEPTH));
	assign q_empty = (s_q.cnt == '0);

	////////////////////////////////////////////////////////////////////////////////
	// memory ports
	// plain always: the bank and result arrays also get their start contents from the initial block
	always @(posedge core_clk)
	begin
		// capture bank is the one not working; roles flip on xform_done
		if (cap_wr.we)
		begin
			bank_ph[~s_q.bank][cap_wr.addr] <= cap_wr.phase;
			bank_qd[~s_q.bank][cap_wr.addr] <= cap_wr.quad;
		end
		if (work_wr.we)
		begin
			bank_ph[s_q.bank][work_wr.addr] <= work_wr.phase;
			bank_qd[s_q.bank][work_wr.addr] <= work_wr.quad;
		end
		work_rd_q <= {bank_qd[s_q.bank][work_raddr], bank_ph[s_q.bank][work_raddr]};
		if (res_wr.we)
		begin
			res_ph[res_wr.addr] <= res_wr.phase;
			res_qd[res_wr.addr] <= res_wr.quad;
		end
		// same address for both halves keeps one bin per pair
		rd_ph_q <= res_ph[s_q.rd_addr];
		rd_qd_q <= res_qd[s_q.rd_addr];
		if (q_push)
			queue[s_q.wp] <= s_q.pair;
		q_rd_q <= queue[s_q.rp];
	end

	////////////////////////////////////////////////////////////////////////////////
	// magnitude pipeline, one pair every cycle
	always_ff @(posedge core_clk)
	begin
		op_ph_q   <= rd_ph_q;
		op_qd_q   <= rd_qd_q;
		sq_ph_p_q <= frm_square(op_ph_q);
		sq_qd_p_q <= frm_square(op_qd_q);
		sq_ph_q   <= sq_ph_p_q;
		sq_qd_q   <= sq_qd_p_q;
		add_a_q   <= sq_ph_q;
		add_b_q   <= sq_qd_q;
	end

	////////////////////////////////////////////////////////////////////////////////
	// control
	assign q_push = s_q.pair_v && !q_full;
	// one word in flight at most, so a fresh head is never overwritten unseen
	assign q_pop  = !q_empty && !s_q.wdata[0] && (!s_q.out.valid || host_ready);

	always_comb
	begin
		s_d = s_q;
		s_d.ack   = 1'b0;
		s_d.rdata = 32'h0000_0000;
		if (xform_done)
			s_d.bank = ~s_q.bank;
		// readout follows the core: starts after a completed transform while run is set and no readout is under way
		unique case (s_q.rd_st)
			RD_IDLE:
			begin
				if (xform_done && s_q.run)
				begin
					s_d.rd_st   = RD_SCAN;
					s_d.rd_addr = '0;
				end
			end
			RD_SCAN:
			begin
				s_d.rd_addr = AW'(s_q.rd_addr + 1'b1);
				if (s_q.rd_addr == AW'(DEPTH - 2))
					s_d.rd_st = RD_LAST;
			end
			RD_LAST:
				s_d.rd_st = RD_IDLE;
			default:
				s_d.rd_st = RD_IDLE;
		endcase
		// read data stands one cycle after the address, so pair strobe follows rd_v directly
		s_d.rd_v   = (s_q.rd_st != RD_IDLE);
		s_d.pair_v = s_q.rd_v;
		s_d.pair   = {rd_qd_q, rd_ph_q};
		s_d.mv     = {s_q.mv[MUL_LAT-2:0], s_q.pair_v};
		s_d.sum_v  = s_q.mv[MUL_LAT-1];
		if (s_q.mv[MUL_LAT-1])
			s_d.mag = DW'(add_a_q + add_b_q);
		// queue bookkeeping, no occupancy exported
		if (q_push)
			s_d.wp = frm_inc(s_q.wp);
		if (q_pop)
			s_d.rp = frm_inc(s_q.rp);
		s_d.cnt = (s_q.cnt + (QPW+1)'(q_push)) - (QPW+1)'(q_pop);
		if (host_ready && s_q.out.valid)
			s_d.out.valid = 1'b0;
		if (s_q.wdata[0])
		begin
			s_d.out.valid = 1'b1;
			s_d.out.data  = q_rd_q;
		end
		s_d.wdata = {31'h0000_0000, q_pop};
		// bus: one wait cycle, answer on the next edge
		if ((avs_read || avs_write) && !s_q.ack)
		begin
			s_d.ack = 1'b1;
			if (avs_write && avs_address == REG_CTRL)
				s_d.run = avs_writedata[CTRL_RUN];
			if (avs_read)
			begin
				unique case (avs_address)
					REG_CTRL: s_d.rdata[CTRL_RUN] = s_q.run;
					REG_STAT:
					begin
						s_d.rdata[STAT_BANK]  = s_q.bank;
						s_d.rdata[STAT_FULL]  = q_full;
						s_d.rdata[STAT_EMPTY] = q_empty;
					end
					REG_MAG: s_d.rdata[DW-1:0] = s_q.mag;
					default: s_d.rdata = 32'h0000_0000;
				endcase
			end
		end
		if (srst)
		begin
			s_d       = '0;
			s_d.run   = 1'b1;
			s_d.rd_st = RD_IDLE;
		end
	end

	always_ff @(posedge core_clk)
		s_q <= s_d;

	assign work_rdata      = work_rd_q;
	assign mag_a           = s_q.mag;
	assign host_word       = s_q.out;
	assign avs_readdata    = s_q.rdata;
	assign avs_waitrequest = !s_q.ack;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	localparam int SUM_DLY = 4;

	sequence pair_in_s;
		s_q.pair_v;
	endsequence
	sequence sum_out_s;
		##SUM_DLY s_q.sum_v;
	endsequence

	mag_timing_a: assert property (pair_in_s |-> sum_out_s)
		else $error("sum strobe not at pipeline latency");
	add_result_a: assert property (s_q.mv[MUL_LAT-1] |=> mag_a == DW'($past(add_a_q) + $past(add_b_q)))
		else $error("magnitude mismatch");
	queue_full_a: assert property (q_full |-> !q_push)
		else $error("push while full");
	queue_empty_a: assert property (q_empty |-> !q_pop)
		else $error("pop while empty");
	queue_depth_a: assert property (s_q.cnt <= (QPW+1)'(QDEPTH))
		else $error("queue count over depth");
	bank_swap_a: assert property (xform_done |=> s_q.bank != $past(s_q.bank))
		else $error("bank did not swap");
	pair_pack_a: assert property (s_q.rd_v |=> s_q.pair_v && s_q.pair == {$past(rd_qd_q), $past(rd_ph_q)})
		else $error("pair packing wrong");
	host_hold_a: assert property (host_word.valid && !host_ready |=> $stable(host_word))
		else $error("host word changed before taken");
	square_op_a: assert property (##1 sq_ph_p_q == frm_square($past(op_ph_q)))
		else $error("square wrong");
	read_scan_a: assert property (s_q.rd_st == RD_SCAN |=> s_q.rd_addr == AW'($past(s_q.rd_addr) + 1'b1))
		else $error("scan address skipped");
	bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
endmodule

// ==== tb/fft_result_magnitude_stage_tb_top.sv ====
// Purpose: self-checking bench for the transform result magnitude stage
// Assumes: core model deposits results; bench is host, bus master and loader
// Notes:   expectations come from the key pattern, bench-written values and reset constants, never from the stage
`timescale 1ns/1ps
module fft_result_magnitude_stage_tb_top;
	import frm_pkg::*;
	logic        core_clk = 0, srst = 1, go = 0, host_ready = 0, xform_done, avs_read = 0, avs_write = 0, avs_waitrequest;
	logic [3:0]  avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata, rd, work_rdata, wa, wb;
	logic [15:0] key = '0, mag_a, e;
	logic [10:0] lim = '0;
	logic [9:0]  work_raddr = '0;
	frm_wr_t     cap_wr = '0, work_wr = '0, res_wr;
	frm_word_t   host_word;
	int          bad_count = 0, n_checks = 0, seed = 73950, i, k;
	always #12.5 core_clk = ~core_clk;
	frm_stage dut_u (.core_clk(core_clk), .srst(srst), .cap_wr(cap_wr), .work_wr(work_wr), .work_raddr(work_raddr),
		.work_rdata(work_rdata), .res_wr(res_wr), .xform_done(xform_done), .mag_a(mag_a), .host_word(host_word),
		.host_ready(host_ready), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	frm_core_model core_u (.core_clk(core_clk), .go(go), .key(key), .lim(lim), .res_wr(res_wr),
		.xform_done(xform_done));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] sq(input logic signed [15:0] v);
		logic signed [31:0] p;
		p = v * v;
		return p[30:15];
	endfunction
	function automatic logic [31:0] word(input int a);
		return (a < lim) ? {16'(a * 7) - key, key ^ 16'(a * 13)} : 32'h0;
	endfunction
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x)
		begin
			bad_count++;
			$display("BAD %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d bad %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
		int t;
		avs_read <= r;
		avs_write <= !r;
		avs_address <= a;
		avs_writedata <= wd;
		for (t = 0; t < 50; t++)
		begin
			@(posedge core_clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
		if (t == 50)
		begin
			bad_count++;
			wrap_up();
		end
	endtask
	task automatic wrd(input logic [31:0] x);
		work_raddr <= 10'h5;
		repeat (3) @(posedge core_clk);
		chk("work", x, work_rdata);
	endtask
	task automatic run_xf(input logic r, input int l);
		bus(1'b0, REG_CTRL, {31'h0, r}, rd);
		key <= 16'($random(seed));
		lim <= 11'(l);
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		i = 0;
		for (k = 0; k < 6000; k++)
		begin
			@(posedge core_clk);
			if (host_word.valid === 1'b1 && host_ready === 1'b1)
			begin
				chk("word", word(i), host_word.data);
				i++;
			end
			host_ready <= ($random(seed) % 4) != 0;
		end
		chk("count", r ? 32'd1024 : 32'd0, 32'(i));
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		wa = $random(seed);
		wb = $random(seed);
		repeat (20) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		bus(1'b1, REG_CTRL, '0, rd);
		chk("ctrl", 32'h1, rd);
		bus(1'b1, REG_STAT, '0, rd);
		chk("stat", 32'h4, rd);
		bus(1'b0, 4'hC, 32'hFFFFFFFF, rd);
		bus(1'b1, 4'hC, '0, rd);
		chk("unmapped", 32'h0, rd);
		wrd(32'h0);
		work_wr <= '{1'b1, 10'h5, wa[15:0], wa[31:16]};
		cap_wr <= '{1'b1, 10'h5, wb[15:0], wb[31:16]};
		@(posedge core_clk);
		work_wr.we <= 1'b0;
		cap_wr.we <= 1'b0;
		wrd(wa);
		run_xf(1'b1, 512);
		run_xf(1'b0, 1024);
		run_xf(1'b1, 1024);
		wa = word(1023);
		e = sq(wa[15:0]) + sq(wa[31:16]);
		chk("mag_a", {16'h0, e}, {16'h0, mag_a});
		bus(1'b1, REG_MAG, '0, rd);
		chk("mag_reg", {16'h0, e}, {16'h0, rd[15:0]});
		bus(1'b1, REG_STAT, '0, rd);
		chk("bank", 32'h5, rd);
		wrd(wb);
		wrap_up();
	end
endmodule

// ==== tb/frm_core_model.sv ====
// Purpose: transform core stand-in that deposits one result block, then pulses done
// Assumes: go is a one-cycle pulse from the bench
// Notes:   values follow a key pattern so the bench can predict them
`timescale 1ns/1ps
module frm_core_model
	import frm_pkg::*;
(
	// clock
	input  wire logic        core_clk,
	// control from bench
	input  wire logic        go,
	input  wire logic [15:0] key,
	input  wire logic [10:0] lim,
	// toward the stage
	output frm_pkg::frm_wr_t res_wr,
	output logic             xform_done
);
	int n = 0;
	initial
	begin
		res_wr = '0;
		xform_done = 1'b0;
	end
	always @(posedge core_clk)
	begin
		xform_done <= 1'b0;
		// idle data lines toggle so a stale value never looks valid
		res_wr <= '{1'b0, ~res_wr.addr, ~res_wr.phase, ~res_wr.quad};
		if (go)
			n <= 1;
		else if (n > 0 && n <= 1024)
		begin
			if (n - 1 < lim)
				res_wr <= '{1'b1, 10'(n - 1), key ^ 16'((n - 1) * 13), 16'((n - 1) * 7) - key};
			n <= n + 1;
		end
		else if (n == 1025)
		begin
			xform_done <= 1'b1;
			n <= 0;
		end
	end
endmodule
